// File: design/sbl_top.sv
// Serial interface top: register port, holding buffers, transmitter with
// break, receiver, and LIN mode selection of the rate generator.
// Assumes a single-cycle register master on the bus clock and an
// asynchronous receive pin.
//
// How it works
// RL1: Data address writes transmit, reads receive buffer
// RL2: Holding buffers load shifters in parallel
// RL3: Prescaler field selects divide by 1,3,4,13
// RL4: Transmit divisor is two to field power
// RL5: Receive divisor is two to field power
// RL6: Nonzero extended receive value divides receive rate
// RL7: Nonzero extended transmit value divides transmit rate
// RL8: Extended prescalers reset to zero
// RL9: Follower mode stops conventional and extended generators
// RL10: Follower mode uses shared LIN generator
// RL11: Follower mode remaps prescaler addresses to LIN registers
// RL12: Software picks eight bits and sets LIN enable
// RL13: Leader break request sends thirteen low bits
// RL14: Leader mode uses conventional or extended rates
// RL15: Follower break request does nothing
// RL16: Software configures LIN before LIN divider writes
// RL17: Leader header: break, 0x55, wait, identifier
// RL18: Word length selects eight or nine data bits
// RL19: Break follows the word in progress
// RL20: Zero extended value falls back to conventional rate
// RL21: Data writes never alter data reads
//
// Added by the designer: the strobed register port and the address map.
`default_nettype none

module sbl_top (
   input wire logic i_mclk,        // Bus clock, 200 MHz
   input wire logic i_rstn,        // Sync reset, active low
   input wire logic [2:0] i_addr,  // Register address
   input wire logic [7:0] i_wdata, // Write data
   input wire logic i_wr,          // Write strobe
   input wire logic i_rd,          // Read strobe
   output logic [7:0] o_rdata,     // Read data, cycle after strobe
   input wire logic i_rxd,         // Serial receive pin
   output logic o_txd              // Serial transmit pin
);
   typedef struct packed {
      logic [7:0] baud;
      logic [7:0] ext_rx;
      logic [7:0] ext_tx;
      logic [7:0] lin_div;
      logic [3:0] lin_frac;
      logic [7:0] ctrl;
      logic [7:0] tx_hold;
      logic tx_hold_b8;
      logic tx_empty;
      logic tx_done;
      logic brk_prev;
      logic brk_pend;
      sbl_pkg::sbl_tx_state_type tx_state;
      logic [10:0] tx_sh;
      logic [3:0] tx_os;
      logic [3:0] tx_bits;
      logic txd;
      logic rx_meta;
      logic rx_sync;
      logic rx_busy;
      logic [3:0] rx_os;
      logic [3:0] rx_bits;
      logic [8:0] rx_sh;
      logic [7:0] rx_hold;
      logic rx_b8;
      logic rx_ready;
      logic [7:0] rdata;
   } sbl_top_state_type;

   sbl_top_state_type st_q;
   sbl_top_state_type st_d;
   logic word9;
   logic follower;
   logic lin_leader;
   logic tx_load;
   logic brk_start;
   logic rx_load;
   logic tx_bit_end;
   logic [3:0] frame_last;

   sbl_rate_if u_rif ();

   // Settings toward the rate generator
   assign u_rif.baud = st_q.baud;
   assign u_rif.ext_rx = st_q.ext_rx;
   assign u_rif.ext_tx = st_q.ext_tx;
   assign u_rif.follower = follower;
   assign u_rif.lin_div = st_q.lin_div;
   assign u_rif.lin_frac = st_q.lin_frac;

   sbl_rate_gen u_rate (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .rif(u_rif)
   );

   // Mode decode from the control register
   assign word9 = st_q.ctrl[sbl_pkg::SBL_C_WORD9];
   assign follower = st_q.ctrl[sbl_pkg::SBL_C_LINEN] && st_q.ctrl[sbl_pkg::SBL_C_FOLLOW];
   assign lin_leader = st_q.ctrl[sbl_pkg::SBL_C_LINEN] && !st_q.ctrl[sbl_pkg::SBL_C_FOLLOW];
   assign frame_last = word9 ? sbl_pkg::SBL_LAST9 : sbl_pkg::SBL_LAST8; // RL18
   assign tx_bit_end = u_rif.tx_tick && st_q.tx_os == sbl_pkg::SBL_OS_LAST;

   // Transmit start conditions
   assign brk_start = st_q.tx_state == sbl_pkg::SBL_TX_IDLE && st_q.ctrl[sbl_pkg::SBL_C_TXEN]
                      && st_q.brk_pend; // RL19
   assign tx_load = st_q.tx_state == sbl_pkg::SBL_TX_IDLE && st_q.ctrl[sbl_pkg::SBL_C_TXEN]
                    && !st_q.brk_pend && !st_q.tx_empty;

   // Receive stop-bit sample finishes a character
   assign rx_load = st_q.ctrl[sbl_pkg::SBL_C_RXEN] && st_q.rx_busy && u_rif.rx_tick
                    && st_q.rx_os == sbl_pkg::SBL_RX_MID && st_q.rx_bits == frame_last;

   // Next-state logic
   always_comb begin
      st_d = st_q;
      st_d.rdata = 8'h00;

      // Break request: rising edge arms, follower mode disarms
      st_d.brk_prev = st_q.ctrl[sbl_pkg::SBL_C_BREAK];
      if (follower) begin
         st_d.brk_pend = 1'b0; // RL15
      end else if (st_q.ctrl[sbl_pkg::SBL_C_BREAK] && !st_q.brk_prev) begin
         st_d.brk_pend = 1'b1; // RL13
      end

      // Transmitter
      if (u_rif.tx_tick) begin
         st_d.tx_os = st_q.tx_os + 4'h1;
      end
      case (st_q.tx_state)
         sbl_pkg::SBL_TX_IDLE: begin
            if (brk_start) begin
               st_d.tx_state = sbl_pkg::SBL_TX_BREAK;
               st_d.tx_bits = lin_leader ? sbl_pkg::SBL_BRK_LIN_LAST : frame_last; // RL13
               st_d.tx_os = 4'h0;
               st_d.brk_pend = 1'b0;
            end else if (tx_load) begin
               // Parallel load: start, data, ninth bit, stop
               st_d.tx_sh = {1'b1, word9 ? st_q.tx_hold_b8 : 1'b1, st_q.tx_hold, 1'b0}; // RL2
               st_d.tx_bits = frame_last; // RL18
               st_d.tx_state = sbl_pkg::SBL_TX_SEND;
               st_d.tx_os = 4'h0;
               st_d.tx_empty = 1'b1;
               st_d.tx_done = 1'b0;
            end
         end
         sbl_pkg::SBL_TX_SEND: begin
            if (tx_bit_end) begin
               if (st_q.tx_bits == 4'h0) begin
                  st_d.tx_state = sbl_pkg::SBL_TX_IDLE;
                  st_d.tx_done = 1'b1;
               end else begin
                  st_d.tx_sh = {1'b1, st_q.tx_sh[10:1]};
                  st_d.tx_bits = st_q.tx_bits - 4'h1;
               end
            end
         end
         sbl_pkg::SBL_TX_BREAK: begin
            // Low bits, then one stop bit through the send path
            if (tx_bit_end) begin
               if (st_q.tx_bits == 4'h0) begin
                  st_d.tx_state = sbl_pkg::SBL_TX_SEND;
                  st_d.tx_sh = 11'h7ff;
               end else begin
                  st_d.tx_bits = st_q.tx_bits - 4'h1;
               end
            end
         end
         default: begin
            st_d.tx_state = sbl_pkg::SBL_TX_IDLE;
         end
      endcase
      case (st_d.tx_state)
         sbl_pkg::SBL_TX_SEND: st_d.txd = st_d.tx_sh[0];
         sbl_pkg::SBL_TX_BREAK: st_d.txd = 1'b0;
         default: st_d.txd = 1'b1;
      endcase

      // Receive pin synchroniser
      st_d.rx_meta = i_rxd;
      st_d.rx_sync = st_q.rx_meta;

      // Receiver, 16x oversampled, bit sampled mid-cell
      if (!st_q.ctrl[sbl_pkg::SBL_C_RXEN]) begin
         st_d.rx_busy = 1'b0;
      end else if (u_rif.rx_tick) begin
         if (!st_q.rx_busy) begin
            if (!st_q.rx_sync) begin
               st_d.rx_busy = 1'b1;
               st_d.rx_os = 4'h0;
               st_d.rx_bits = 4'h0;
            end
         end else begin
            st_d.rx_os = st_q.rx_os + 4'h1;
            if (st_q.rx_os == sbl_pkg::SBL_RX_MID) begin
               st_d.rx_os = 4'h8;
               if (st_q.rx_bits == 4'h0 && st_q.rx_sync) begin
                  st_d.rx_busy = 1'b0;
               end else if (rx_load) begin
                  st_d.rx_busy = 1'b0;
               end else begin
                  st_d.rx_bits = st_q.rx_bits + 4'h1;
                  if (st_q.rx_bits != 4'h0) begin
                     st_d.rx_sh = {st_q.rx_sync, st_q.rx_sh[8:1]};
                  end
               end
            end
         end
      end

      // Register reads: data cleared flag, then load sets it
      if (i_rd) begin
         case (i_addr)
            sbl_pkg::SBL_A_DATA: begin
               st_d.rdata = st_q.rx_hold; // RL1 RL21
               st_d.rx_ready = 1'b0;
            end
            sbl_pkg::SBL_A_BAUD: st_d.rdata = follower ? st_q.lin_div : st_q.baud; // RL11
            sbl_pkg::SBL_A_ERX: st_d.rdata = follower ? sbl_pkg::SBL_HDR_LEN : st_q.ext_rx;
            sbl_pkg::SBL_A_ETX: st_d.rdata = follower ? {4'h0, st_q.lin_frac} : st_q.ext_tx;
            sbl_pkg::SBL_A_CTRL: st_d.rdata = st_q.ctrl;
            sbl_pkg::SBL_A_STAT: st_d.rdata = {st_q.tx_empty, st_q.tx_done, st_q.rx_ready,
                                               4'h0, st_q.rx_b8};
            default: st_d.rdata = 8'h00;
         endcase
      end
      if (rx_load) begin
         st_d.rx_hold = word9 ? st_q.rx_sh[7:0] : st_q.rx_sh[8:1]; // RL2
         st_d.rx_b8 = word9 ? st_q.rx_sh[8] : 1'b0;
         st_d.rx_ready = 1'b1;
      end

      // Register writes
      if (i_wr) begin
         case (i_addr)
            sbl_pkg::SBL_A_DATA: begin
               st_d.tx_hold = i_wdata; // RL1
               st_d.tx_hold_b8 = st_q.ctrl[sbl_pkg::SBL_C_TXB8];
               st_d.tx_empty = 1'b0;
               st_d.tx_done = 1'b0;
            end
            sbl_pkg::SBL_A_BAUD: begin
               if (follower) begin
                  st_d.lin_div = i_wdata; // RL11 RL16
               end else begin
                  st_d.baud = i_wdata;
               end
            end
            sbl_pkg::SBL_A_ERX: begin
               if (!follower) begin
                  st_d.ext_rx = i_wdata;
               end
            end
            sbl_pkg::SBL_A_ETX: begin
               if (follower) begin
                  st_d.lin_frac = i_wdata[3:0]; // RL11
               end else begin
                  st_d.ext_tx = i_wdata;
               end
            end
            sbl_pkg::SBL_A_CTRL: st_d.ctrl = i_wdata;
            default: ;
         endcase
      end
   end

   // State register with reset values
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         st_q <= '0;
         st_q.baud <= sbl_pkg::SBL_BAUD_RST;
         st_q.ext_rx <= sbl_pkg::SBL_EXT_RST; // RL8
         st_q.ext_tx <= sbl_pkg::SBL_EXT_RST; // RL8
         st_q.lin_div <= sbl_pkg::SBL_LIN_RST;
         st_q.lin_frac <= sbl_pkg::SBL_FRAC_RST;
         st_q.ctrl <= sbl_pkg::SBL_CTRL_RST;
         st_q.tx_empty <= 1'b1;
         st_q.tx_state <= sbl_pkg::SBL_TX_IDLE;
         st_q.txd <= 1'b1;
         st_q.rx_meta <= 1'b1;
         st_q.rx_sync <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_rdata = st_q.rdata;
   assign o_txd = st_q.txd;

   AST_RD_RX: // RL1
   assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (i_rd && i_addr == sbl_pkg::SBL_A_DATA) |=> o_rdata == $past(st_q.rx_hold))
   else $error("data read does not return receive buffer");

   AST_WR_NO_ECHO: // RL21
   assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (i_wr && i_addr == sbl_pkg::SBL_A_DATA && !rx_load) |=> $stable(st_q.rx_hold))
   else $error("data write altered receive buffer");

   AST_TX_LOAD: // RL2
   assert property (@(posedge i_mclk) disable iff (!i_rstn)
      tx_load |=> st_q.tx_sh[8:1] == $past(st_q.tx_hold) && !st_q.tx_sh[0]
                  && (st_q.tx_empty || $past(i_wr && i_addr == sbl_pkg::SBL_A_DATA)))
   else $error("transmit shifter not loaded from holding buffer");

   AST_RX_LOAD: // RL2
   assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (rx_load && !word9) |=> st_q.rx_hold == $past(st_q.rx_sh[8:1]) && st_q.rx_ready)
   else $error("receive buffer not loaded from shifter");

   AST_EXT_RST: // RL8
   assert property (@(posedge i_mclk) disable iff (!i_rstn)
      !$past(i_rstn) |-> st_q.ext_rx == 8'h00 && st_q.ext_tx == 8'h00)
   else $error("extended prescaler not zero after reset");

   AST_BRK13: // RL13
   assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (brk_start && lin_leader) |=> st_q.tx_bits == 4'hc && !o_txd)
   else $error("leader break length wrong");

   AST_FOLLOW_NOBRK: // RL15
   assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (follower && $past(follower)) |-> !brk_start)
   else $error("break sent in follower mode");

   AST_WLEN: // RL18
   assert property (@(posedge i_mclk) disable iff (!i_rstn)
      tx_load |=> st_q.tx_bits == ($past(word9) ? 4'ha : 4'h9))
   else $error("frame length does not follow word length");

   AST_BRK_AFTER: // RL19
   assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (st_q.tx_state == sbl_pkg::SBL_TX_SEND) |-> !brk_start)
   else $error("break cut into a word in progress");
endmodule // sbl_top

`default_nettype wire

// File: design/sbl_pkg.sv
// Shared constants for the serial block: register map, field positions,
// reset values, rate factors, frame bit counts and transmitter states.
// Assumes an 8-bit register port with a 3-bit word address.
`default_nettype none

package sbl_pkg;
   // Register addresses
   localparam logic [2:0] SBL_A_DATA = 3'h0;
   localparam logic [2:0] SBL_A_BAUD = 3'h1;
   localparam logic [2:0] SBL_A_ERX = 3'h2;
   localparam logic [2:0] SBL_A_ETX = 3'h3;
   localparam logic [2:0] SBL_A_CTRL = 3'h4;
   localparam logic [2:0] SBL_A_STAT = 3'h5;
   // Baud select field positions
   localparam int SBL_PR_LSB = 6;
   localparam int SBL_TXD_LSB = 3;
   localparam int SBL_RXD_LSB = 0;
   // Control register bits
   localparam int SBL_C_WORD9 = 0;
   localparam int SBL_C_TXB8 = 1;
   localparam int SBL_C_TXEN = 2;
   localparam int SBL_C_RXEN = 3;
   localparam int SBL_C_BREAK = 4;
   localparam int SBL_C_LINEN = 5;
   localparam int SBL_C_FOLLOW = 6;
   // Reset values
   localparam logic [7:0] SBL_BAUD_RST = 8'h00;
   localparam logic [7:0] SBL_EXT_RST = 8'h00;
   localparam logic [7:0] SBL_CTRL_RST = 8'h00;
   localparam logic [7:0] SBL_LIN_RST = 8'h00;
   localparam logic [3:0] SBL_FRAC_RST = 4'h0;
   localparam logic [7:0] SBL_HDR_LEN = 8'h00;
   // First prescaler factors
   localparam logic [7:0] SBL_PR_F0 = 8'h01;
   localparam logic [7:0] SBL_PR_F1 = 8'h03;
   localparam logic [7:0] SBL_PR_F2 = 8'h04;
   localparam logic [7:0] SBL_PR_F3 = 8'h0d;
   // Oversampling and frame counts (bit counts minus one)
   localparam logic [3:0] SBL_OS_LAST = 4'hf;
   localparam logic [3:0] SBL_RX_MID = 4'h7;
   localparam logic [3:0] SBL_LAST8 = 4'h9;
   localparam logic [3:0] SBL_LAST9 = 4'ha;
   localparam logic [3:0] SBL_BRK_LIN_LAST = 4'hc;

   typedef enum logic [1:0] {
      SBL_TX_IDLE = 2'b00,
      SBL_TX_SEND = 2'b01,
      SBL_TX_BREAK = 2'b10
   } sbl_tx_state_type;
endpackage

`default_nettype wire

// File: design/sbl_rate_if.sv
// Rate settings in, oversampling ticks out, between the serial top and
// its rate generator. Assumes both ends share one clock.
`default_nettype none

interface sbl_rate_if;
   logic [7:0] baud;
   logic [7:0] ext_rx;
   logic [7:0] ext_tx;
   logic follower;
   logic [7:0] lin_div;
   logic [3:0] lin_frac;
   logic tx_tick;
   logic rx_tick;
   modport gen (input baud, ext_rx, ext_tx, follower, lin_div, lin_frac,
                output tx_tick, rx_tick);
   modport user (output baud, ext_rx, ext_tx, follower, lin_div, lin_frac,
                 input tx_tick, rx_tick);
endinterface

`default_nettype wire

// File: design/sbl_pulse_div.sv
// Enable divider: one output pulse for every i_div input pulses.
// Assumes one clock; a divisor of zero stops the output.
`default_nettype none

module sbl_pulse_div #(
   parameter int WIDTH = 8
) (
   input wire logic i_mclk,            // Bus clock
   input wire logic i_rstn,            // Sync reset, active low
   input wire logic i_en,              // Input rate pulse
   input wire logic [WIDTH-1:0] i_div, // Divisor, zero stops
   output logic o_tick                 // Divided pulse
);
   if (WIDTH < 1) begin : g_bad_width
      $error("sbl_pulse_div: WIDTH must be at least 1");
   end

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } sbl_div_state_type;

   sbl_div_state_type st_q;
   sbl_div_state_type st_d;

   // Count input pulses, wrap at divisor
   always_comb begin
      st_d = st_q;
      o_tick = 1'b0;
      if (i_div == '0) begin
         st_d.cnt = '0;
      end else if (i_en) begin
         if (st_q.cnt >= i_div - {{(WIDTH-1){1'b0}}, 1'b1}) begin
            st_d.cnt = '0;
            o_tick = 1'b1;
         end else begin
            st_d.cnt = st_q.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   // State register
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule // sbl_pulse_div

`default_nettype wire

// File: design/sbl_rate_gen.sv
// Baud rate generator: conventional, extended and follower-mode paths,
// each delivering a 16x oversampling tick per direction.
// Assumes settings come from registers on the same clock.
`default_nettype none

module sbl_rate_gen (
   input wire logic i_mclk,   // Bus clock
   input wire logic i_rstn,   // Sync reset, active low
   sbl_rate_if.gen rif        // Settings and ticks
);
   typedef struct packed {
      logic [7:0] cnt;
      logic [3:0] acc;
      logic extra;
      logic [7:0] gap;
      logic seen;
      logic [7:0] baud_prev;
   } sbl_rgen_state_type;

   sbl_rgen_state_type st_q;
   sbl_rgen_state_type st_d;
   logic conv_en;
   logic pr_tick;
   logic tx_conv;
   logic rx_conv;
   logic tx_ext;
   logic rx_ext;
   logic lin_tick;
   logic [7:0] pr_val;
   logic [7:0] tx_val;
   logic [7:0] rx_val;

   // Prescaler factor and power-of-two divisors
   always_comb begin
      case (rif.baud[sbl_pkg::SBL_PR_LSB +: 2])
         2'b00: pr_val = sbl_pkg::SBL_PR_F0; // RL3
         2'b01: pr_val = sbl_pkg::SBL_PR_F1;
         2'b10: pr_val = sbl_pkg::SBL_PR_F2;
         default: pr_val = sbl_pkg::SBL_PR_F3;
      endcase
      tx_val = 8'h01 << rif.baud[sbl_pkg::SBL_TXD_LSB +: 3]; // RL4
      rx_val = 8'h01 << rif.baud[sbl_pkg::SBL_RXD_LSB +: 3]; // RL5
   end

   // Conventional and extended stages stop in follower mode
   assign conv_en = !rif.follower; // RL9

   sbl_pulse_div #(.WIDTH(8)) u_pr (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_en(conv_en), .i_div(pr_val), .o_tick(pr_tick));
   sbl_pulse_div #(.WIDTH(8)) u_txd (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_en(pr_tick), .i_div(tx_val), .o_tick(tx_conv));
   sbl_pulse_div #(.WIDTH(8)) u_rxd (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_en(pr_tick), .i_div(rx_val), .o_tick(rx_conv));
   sbl_pulse_div #(.WIDTH(8)) u_etx (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_en(tx_conv), .i_div(rif.ext_tx), .o_tick(tx_ext));
   sbl_pulse_div #(.WIDTH(8)) u_erx (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_en(rx_conv), .i_div(rif.ext_rx), .o_tick(rx_ext));

   // Follower generator with fractional stretch, plus period watch
   always_comb begin
      logic [4:0] sum;
      sum = 5'h00;
      st_d = st_q;
      lin_tick = 1'b0;
      if (rif.follower && rif.lin_div != 8'h00) begin
         if (st_q.cnt >= rif.lin_div - 8'h01 + {7'h00, st_q.extra}) begin
            lin_tick = 1'b1;
            st_d.cnt = 8'h00;
            sum = {1'b0, st_q.acc} + {1'b0, rif.lin_frac};
            st_d.acc = sum[3:0];
            st_d.extra = sum[4];
         end else begin
            st_d.cnt = st_q.cnt + 8'h01;
         end
      end else begin
         st_d.cnt = 8'h00;
         st_d.acc = 4'h0;
         st_d.extra = 1'b0;
      end
      st_d.baud_prev = rif.baud;
      st_d.gap = pr_tick ? 8'h00 : st_q.gap + 8'h01;
      if (rif.baud != st_q.baud_prev || rif.follower) begin
         st_d.seen = 1'b0;
      end else if (pr_tick) begin
         st_d.seen = 1'b1;
      end
   end

   // Tick selection: follower, extended when nonzero, else conventional
   assign rif.tx_tick = rif.follower ? lin_tick :            // RL10
                        (rif.ext_tx != 8'h00) ? tx_ext : tx_conv; // RL7 RL20 RL14
   assign rif.rx_tick = rif.follower ? lin_tick :            // RL10
                        (rif.ext_rx != 8'h00) ? rx_ext : rx_conv; // RL6 RL20 RL14

   // State register
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   AST_PR_PERIOD: // RL3
   assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (pr_tick && st_q.seen && rif.baud == st_q.baud_prev) |-> st_q.gap == pr_val - 8'h01)
   else $error("first prescaler period wrong");

   AST_CONV_OFF: // RL9
   assert property (@(posedge i_mclk) disable iff (!i_rstn)
      rif.follower [*2] |-> !pr_tick && !tx_conv && !rx_conv)
   else $error("conventional generator runs in follower mode");

   AST_LIN_SHARED: // RL10
   assert property (@(posedge i_mclk) disable iff (!i_rstn)
      rif.follower |-> rif.tx_tick == rif.rx_tick)
   else $error("follower ticks differ between directions");
endmodule // sbl_rate_gen

`default_nettype wire

// File: tb/sbl_uart_peer.sv
// Remote serial node: sends one framed byte on the receive pin.
// Assumes the bench clock; the line idles high between frames.
`default_nettype none

module sbl_uart_peer (
   input wire logic i_mclk, // Bench clock
   output logic o_line      // Serial line to the block
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle high from time zero
   initial o_line = 1'b1;
   // Start, eight data bits LSB first, stop; per cycles each
   task automatic send(input logic [7:0] d, input int per);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge i_mclk);
         o_line <= f[i];
         repeat (per - 1) @(posedge i_mclk);
      end
   endtask
endmodule // sbl_uart_peer

`default_nettype wire

// File: tb/sbl_top_tb.sv
// Self-checking bench for the serial top: rates, receive, LIN header, follower.
// Assumes a remote node model drives the receive pin.
`default_nettype none

module sbl_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk = 1'b0;
   logic i_rstn = 1'b0;
   logic [2:0] i_addr = 3'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] o_rdata;
   logic i_rxd;
   logic o_txd;
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;
   sbl_top sbl_top_inst (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_rxd(i_rxd), .o_txd(o_txd));
   sbl_uart_peer sbl_uart_peer_inst (.i_mclk(i_mclk), .o_line(i_rxd));
   // Verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      check_count++;
      if (s !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, s);
         n_errors++;
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input string nm, input logic [2:0] a, input logic [7:0] e);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 chk(nm, {8'h00, e}, {8'h00, o_rdata});
   endtask
   // Waits for a start edge, then samples n bits mid-bit, LSB of p first
   task automatic line(input string nm, input logic [15:0] p, input int n, input int per);
      int k;
      for (k = 0; k < 4000 && o_txd !== 1'b0; k++) @(negedge i_mclk);
      repeat (per / 2) @(negedge i_mclk);
      for (int i = 0; i < n; i++) begin
         chk(nm, {15'h0, p[i]}, {15'h0, o_txd});
         repeat (per) @(negedge i_mclk);
      end
   endtask
   task automatic t_reset();
      rd("baud", 3'h1, 8'h00);
      rd("ext rx", 3'h2, 8'h00);
      rd("ext tx", 3'h3, 8'h00);
      rd("unmapped", 3'h6, 8'h00);
      chk("txd idle", 16'h1, {15'h0, o_txd});
      $display("test reset done");
   endtask
   task automatic t_rates();
      logic [7:0] bd [5] = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'h38};
      int per [5] = '{16, 48, 64, 208, 2048};
      logic [7:0] d;
      wr(3'h4, 8'h0c);
      for (int i = 0; i < 5; i++) begin
         d = 8'ha5 + 8'(i);
         wr(3'h1, bd[i]);
         wr(3'h0, d);
         line("tx frame", {6'h01, d, 1'b0}, 10, per[i]);
      end
      wr(3'h1, 8'h00);
      wr(3'h3, 8'h02);
      wr(3'h0, 8'h3c);
      line("ext tx frame", {6'h01, 8'h3c, 1'b0}, 10, 32);
      wr(3'h4, 8'h0d);
      wr(3'h0, 8'hc3);
      line("nine bit frame", {5'h02, 8'hc3, 1'b0}, 11, 32);
      wr(3'h4, 8'h0c);
      wr(3'h3, 8'h00);
      $display("test rates done");
   endtask
   task automatic t_rx();
      wr(3'h1, 8'h01);
      wr(3'h2, 8'h03);
      sbl_uart_peer_inst.send(8'h96, 96);
      rd("rx data", 3'h0, 8'h96);
      wr(3'h0, 8'h11);
      rd("rx after write", 3'h0, 8'h96);
      line("conv tx", {6'h01, 8'h11, 1'b0}, 10, 16);
      wr(3'h2, 8'h00);
      $display("test receive done");
   endtask
   task automatic t_header();
      wr(3'h1, 8'h00);
      wr(3'h4, 8'h24);
      wr(3'h4, 8'h34);
      wr(3'h4, 8'h24);
      wr(3'h0, 8'h55);
      line("break", 16'h0000, 13, 16);
      chk("break stop", 16'h1, {15'h0, o_txd});
      line("sync", {6'h01, 8'h55, 1'b0}, 10, 16);
      rd("tx empty", 3'h5, 8'h80 | 8'h40);
      wr(3'h0, 8'h2a);
      line("ident", {6'h01, 8'h2a, 1'b0}, 10, 16);
      $display("test header done");
   endtask
   task automatic t_follow();
      logic q;
      q = 1'b1;
      wr(3'h3, 8'h02);
      wr(3'h4, 8'h64);
      wr(3'h1, 8'h03);
      rd("lin div", 3'h1, 8'h03);
      rd("hdr len", 3'h2, 8'h00);
      wr(3'h4, 8'h74);
      repeat (400) begin
         @(negedge i_mclk);
         if (o_txd !== 1'b1) q = 1'b0;
      end
      chk("no break", 16'h1, {15'h0, q});
      wr(3'h0, 8'h5a);
      line("lin frame", {6'h01, 8'h5a, 1'b0}, 10, 48);
      $display("test follower done");
   endtask
   // Bench clock, 5 ns period
   initial begin
      forever #2.5 i_mclk = ~i_mclk;
   end
   // Hang guard
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         results();
      end
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge i_mclk);
      i_rstn <= 1'b1;
      t_reset();
      t_rates();
      t_rx();
      t_header();
      t_follow();
      results();
   end
endmodule // sbl_top_tb

`default_nettype wire
